// >>> stepper_pkg.sv
package stepper_pkg;

  // register bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [2:0] ADDR_CTRL     = 3'h0;
  localparam logic [2:0] ADDR_PERIOD   = 3'h1;
  localparam logic [2:0] ADDR_FAULT    = 3'h2;
  localparam logic [2:0] ADDR_INT_STAT = 3'h3;
  localparam logic [2:0] ADDR_INT_MASK = 3'h4;

  // control register fields
  localparam int CTRL_CHOP_EN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // chopper period in mclk cycles: 10 MHz / 100 = 100 kHz
  localparam logic [7:0] PERIOD_RESET = 8'h64;
  localparam logic [7:0] PERIOD_MIN   = 8'h04;

  // fault register fields
  localparam int FLT_THERMAL_BIT = 0;
  localparam int FLT_OC0_BIT     = 1;
  localparam int FLT_OC1_BIT     = 2;
  localparam int FLT_SUPPLY_BIT  = 3;
  localparam int FLT_STANDBY_BIT = 4;
  localparam int FLT_OSC_BIT     = 5;

  // interrupt status / mask fields
  localparam int IRQ_W           = 4;
  localparam int IRQ_THERMAL_BIT = 0;
  localparam int IRQ_OC0_BIT     = 1;
  localparam int IRQ_OC1_BIT     = 2;
  localparam int IRQ_SUPPLY_BIT  = 3;
  localparam logic [3:0] INT_MASK_RESET = 4'h0;

  // number of bridge phases
  localparam int PHASES = 2;

  // current set-point codes {level_hi, level_lo}
  localparam logic [1:0] SP_FULL = 2'h3;
  localparam logic [1:0] SP_71   = 2'h2;
  localparam logic [1:0] SP_38   = 2'h1;
  localparam logic [1:0] SP_ZERO = 2'h0;

  // set-point in percent of full current
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_71   = 7'h47;
  localparam logic [6:0] PCT_38   = 7'h26;
  localparam logic [6:0] PCT_ZERO = 7'h00;

  // chopper phase states
  typedef enum logic [1:0] {
    CHOP_ON  = 2'b01,
    CHOP_OFF = 2'b10
  } chop_state_type;

endpackage

// >>> phase_if.sv
`timescale 1ns/1ps
interface phase_if;
  logic       dir;
  logic       lvl_hi;
  logic       lvl_lo;
  logic       drive_en;
  logic       pos;
  logic       neg;
  logic       pos_oe;
  logic       neg_oe;
  logic [1:0] sp_code;
  logic [6:0] sp_pct;

  modport ctrl (
    output dir, lvl_hi, lvl_lo, drive_en,
    input  pos, neg, pos_oe, neg_oe, sp_code, sp_pct
  );
  modport bridge (
    input  dir, lvl_hi, lvl_lo, drive_en,
    output pos, neg, pos_oe, neg_oe, sp_code, sp_pct
  );
endinterface

// >>> phase_bridge.sv
`timescale 1ns/1ps
module phase_bridge
  import stepper_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  input  wire logic clk_en_in,
  phase_if.bridge   bus
);

  logic [1:0] code;

  // percent value of a set-point code
  function automatic logic [6:0] pct_of(input logic [1:0] c);
    case (c)
      SP_FULL: pct_of = PCT_FULL;
      SP_71:   pct_of = PCT_71;
      SP_38:   pct_of = PCT_38;
      default: pct_of = PCT_ZERO;
    endcase
  endfunction

  // RULE1 level pair decode
  assign code = {bus.lvl_hi, bus.lvl_lo};

  // set-point registers follow the level inputs even when driving is off
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus.sp_code <= SP_ZERO;
      bus.sp_pct  <= PCT_ZERO;
    end else if (clk_en_in) begin
      bus.sp_code <= code;
      bus.sp_pct  <= pct_of(code);
    end
  end

  // bridge output stage, registered so no decode glitch reaches the pins
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus.pos    <= 1'b0;
      bus.neg    <= 1'b0;
      bus.pos_oe <= 1'b0;
      bus.neg_oe <= 1'b0;
    end else if (clk_en_in) begin
      // RULE2 direction sets polarity
      bus.pos <= bus.dir;
      bus.neg <= ~bus.dir;
      // RULE3 zero level floats both
      bus.pos_oe <= bus.drive_en && (code != SP_ZERO);
      bus.neg_oe <= bus.drive_en && (code != SP_ZERO);
    end
  end

endmodule

// >>> stepper_ctrl.sv
// Summary of operation
// RULE1 - level pair per phase selects 100%, 71%, 38% or zero current
// RULE2 - direction high drives positive high, negative low; low reverses both
// RULE3 - both levels low puts that phase's outputs in high impedance
// RULE4 - standby low stops the chopper oscillator and every output driver
// RULE5 - thermal trip switches all outputs off and latches the fault
// RULE6 - thermal latch clears only on reset or standby high-low-high
// RULE7 - any supply monitor reporting low holds all outputs off
// RULE8 - per-phase overcurrent turns off only that phase and latches
// RULE9 - overcurrent latch clears only on standby high-low-high
// RULE10 - host drives inputs only once motor supply is in range
// RULE11 - each period turn bridge on, off at set-point until next period
// RULE12 - record standby low, clear all latches on return to high
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module stepper_ctrl
  import stepper_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  input  wire logic              clk_en_in,
  input  wire logic              standby_n_in,
  input  wire logic              direction_first_in,
  input  wire logic              direction_second_in,
  input  wire logic              level_in_first_coil_hi_in,
  input  wire logic              level_in_first_coil_lo_in,
  input  wire logic              level_in_second_coil_hi_in,
  input  wire logic              level_in_second_coil_lo_in,
  input  wire logic              thermal_trip_in,
  input  wire logic [1:0]        overcurrent_trip_in,
  input  wire logic              motor_supply_ok_in,
  input  wire logic              logic_supply_ok_in,
  input  wire logic [1:0]        sense_reached_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [DATA_W-1:0]      reg_rdata_out,
  output logic [1:0]             pos_out,
  output logic [1:0]             pos_oe_out,
  output logic [1:0]             neg_out,
  output logic [1:0]             neg_oe_out,
  output logic [3:0]             setpoint_code_out,
  output logic [13:0]            setpoint_pct_out,
  output logic                   chopper_osc_pin_out,
  output logic                   irq_out
);

  // software registers
  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] period_ff;
  logic [IRQ_W-1:0]  int_stat_ff;
  logic [IRQ_W-1:0]  int_mask_ff;
  logic [DATA_W-1:0] rdata_ff;

  // protection state
  logic              thermal_lat_ff;
  logic [1:0]        oc_lat_ff;
  logic              standby_low_seen_ff;
  logic              supply_ok_ff;
  logic              fault_clr;
  logic              supply_ok;
  logic              nxt_thermal_lat;
  logic [1:0]        nxt_oc_lat;

  // chopper state
  logic [DATA_W-1:0] osc_cnt_ff;
  logic              osc_ff;
  logic [DATA_W-1:0] period_eff;
  logic              period_start;
  logic              chop_en;
  logic              osc_wrap;

  // events and bus decode
  logic [IRQ_W-1:0]  events;
  logic [IRQ_W-1:0]  w1c;
  logic              wr_int_stat;
  logic [DATA_W-1:0] fault_view;
  logic [DATA_W-1:0] nxt_rdata;
  logic              wr_ctrl;
  logic              wr_period;
  logic              wr_mask;

  logic [PHASES-1:0] dir_vec;
  logic [PHASES-1:0] hi_vec;
  logic [PHASES-1:0] lo_vec;

  phase_if ph_bus [PHASES] ();

  assign dir_vec = {direction_second_in, direction_first_in};
  assign hi_vec  = {level_in_second_coil_hi_in, level_in_first_coil_hi_in};
  assign lo_vec  = {level_in_second_coil_lo_in, level_in_first_coil_lo_in};

  // monitors do not latch; drive returns once both are good
  // RULE7 both monitors must report good
  assign supply_ok = motor_supply_ok_in & logic_supply_ok_in;

  // a standby pulse shorter than one clock goes unseen
  // RULE12 clear on standby return high
  assign fault_clr = standby_n_in & standby_low_seen_ff;

  // a new trip in the clearing cycle wins over the clear
  // RULE6 thermal latch release
  assign nxt_thermal_lat = thermal_trip_in | (thermal_lat_ff & ~fault_clr);
  // RULE9 overcurrent latch release
  assign nxt_oc_lat = overcurrent_trip_in | (oc_lat_ff & {PHASES{~fault_clr}});

  // standby watcher
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      standby_low_seen_ff <= 1'b0;
    end else if (clk_en_in) begin
      // RULE12 remember low level
      if (!standby_n_in) begin
        standby_low_seen_ff <= 1'b1;
      end else begin
        standby_low_seen_ff <= 1'b0;
      end
    end
  end

  // thermal latch; only reset is a power-on restart here
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      thermal_lat_ff <= 1'b0;
    end else if (clk_en_in) begin
      // RULE5 latch thermal fault
      thermal_lat_ff <= nxt_thermal_lat;
    end
  end

  // per-phase overcurrent latches
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oc_lat_ff <= 2'h0;
    end else if (clk_en_in) begin
      // RULE8 latch per phase
      oc_lat_ff <= nxt_oc_lat;
    end
  end

  // previous supply level, for the dropout event
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      supply_ok_ff <= 1'b0;
    end else if (clk_en_in) begin
      supply_ok_ff <= supply_ok;
    end
  end

  // too short a period would leave no on-time at all
  assign period_eff = (period_ff < PERIOD_MIN) ? PERIOD_MIN : period_ff;
  assign chop_en    = ctrl_ff[CTRL_CHOP_EN_BIT];

  // last count of the period, shared by counter and pin
  assign osc_wrap = osc_cnt_ff >= period_eff - 8'h01;

  // chopper oscillator counter
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_cnt_ff <= 8'h00;
    end else if (clk_en_in) begin
      // RULE4 standby stops oscillator
      if (!standby_n_in || !chop_en) begin
        osc_cnt_ff <= 8'h00;
      end else if (osc_wrap) begin
        osc_cnt_ff <= 8'h00;
      end else begin
        osc_cnt_ff <= osc_cnt_ff + 8'h01;
      end
    end
  end

  // oscillator pin, high for the first half of each period
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_ff <= 1'b0;
    end else if (clk_en_in) begin
      // RULE4 pin quiet in standby
      if (!standby_n_in || !chop_en) begin
        osc_ff <= 1'b0;
      end else if (osc_wrap) begin
        osc_ff <= 1'b1;
      end else begin
        osc_ff <= (osc_cnt_ff + 8'h01) < {1'b0, period_eff[7:1]};
      end
    end
  end

  assign period_start = standby_n_in && chop_en && (osc_cnt_ff == 8'h00);
  assign chopper_osc_pin_out = osc_ff;

  genvar gi;
  generate
    for (gi = 0; gi < PHASES; gi++) begin : g_phase

      // chopper state kept per phase so each has a single driver
      chop_state_type chop_state_ff;

      // per-phase chopper: on at period start, off at set-point
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          chop_state_ff <= CHOP_OFF;
        end else if (clk_en_in) begin
          // RULE11 peak current chopping
          case (chop_state_ff)
            CHOP_OFF: begin
              if (period_start) begin
                chop_state_ff <= CHOP_ON;
              end
            end
            CHOP_ON: begin
              if (!standby_n_in || !chop_en) begin
                chop_state_ff <= CHOP_OFF;
              end else if (sense_reached_in[gi] && !period_start) begin
                chop_state_ff <= CHOP_OFF;
              end
            end
            default: begin
              chop_state_ff <= CHOP_OFF;
            end
          endcase
        end
      end

      assign ph_bus[gi].dir    = dir_vec[gi];
      assign ph_bus[gi].lvl_hi = hi_vec[gi];
      assign ph_bus[gi].lvl_lo = lo_vec[gi];
      // RULE4 standby blocks drivers
      // RULE5 thermal blocks every phase
      // RULE7 supply low blocks drive
      // RULE8 only this phase's latch
      assign ph_bus[gi].drive_en = standby_n_in && supply_ok
                                 && !thermal_lat_ff && !oc_lat_ff[gi]
                                 && (chop_state_ff == CHOP_ON);

      phase_bridge u_bridge (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .clk_en_in (clk_en_in),
        .bus       (ph_bus[gi])
      );

      assign pos_out[gi]    = ph_bus[gi].pos;
      assign neg_out[gi]    = ph_bus[gi].neg;
      assign pos_oe_out[gi] = ph_bus[gi].pos_oe;
      assign neg_oe_out[gi] = ph_bus[gi].neg_oe;
      assign setpoint_code_out[gi*2 +: 2] = ph_bus[gi].sp_code;
      assign setpoint_pct_out[gi*7 +: 7]  = ph_bus[gi].sp_pct;
    end
  endgenerate

  // interrupt events: rising edge of each latch, supply dropout
  assign events[IRQ_THERMAL_BIT] = nxt_thermal_lat & ~thermal_lat_ff;
  assign events[IRQ_OC0_BIT]     = nxt_oc_lat[0] & ~oc_lat_ff[0];
  assign events[IRQ_OC1_BIT]     = nxt_oc_lat[1] & ~oc_lat_ff[1];
  assign events[IRQ_SUPPLY_BIT]  = supply_ok_ff & ~supply_ok;

  assign wr_int_stat = reg_wr_in && (reg_addr_in == ADDR_INT_STAT);
  assign w1c = wr_int_stat ? reg_wdata_in[IRQ_W-1:0] : 4'h0;

  // write decode, one strobe per writable offset
  assign wr_ctrl   = reg_wr_in && (reg_addr_in == ADDR_CTRL);
  assign wr_period = reg_wr_in && (reg_addr_in == ADDR_PERIOD);
  assign wr_mask   = reg_wr_in && (reg_addr_in == ADDR_INT_MASK);

  // control byte, bit 0 enables the chopper
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_ff <= CTRL_RESET;
    end else if (clk_en_in && wr_ctrl) begin
      ctrl_ff <= reg_wdata_in;
    end
  end

  // chopper period; small values are clamped on use, not on write
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      period_ff <= PERIOD_RESET;
    end else if (clk_en_in && wr_period) begin
      period_ff <= reg_wdata_in;
    end
  end

  // interrupt mask, same layout as the status register
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_mask_ff <= INT_MASK_RESET;
    end else if (clk_en_in && wr_mask) begin
      int_mask_ff <= reg_wdata_in[IRQ_W-1:0];
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_stat_ff <= 4'h0;
    end else if (clk_en_in) begin
      int_stat_ff <= events | (int_stat_ff & ~w1c);
    end
  end

  assign irq_out = |(int_stat_ff & int_mask_ff);

  // live fault view for software
  always_comb begin
    fault_view                  = 8'h00;
    fault_view[FLT_THERMAL_BIT] = thermal_lat_ff;
    fault_view[FLT_OC0_BIT]     = oc_lat_ff[0];
    fault_view[FLT_OC1_BIT]     = oc_lat_ff[1];
    fault_view[FLT_SUPPLY_BIT]  = ~supply_ok;
    fault_view[FLT_STANDBY_BIT] = standby_n_in;
    fault_view[FLT_OSC_BIT]     = osc_ff;
  end

  // read multiplexer; zero outside a read so stale data never lingers
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_CTRL:     nxt_rdata = ctrl_ff;
        ADDR_PERIOD:   nxt_rdata = period_ff;
        ADDR_FAULT:    nxt_rdata = fault_view;
        ADDR_INT_STAT: nxt_rdata = {4'h0, int_stat_ff};
        ADDR_INT_MASK: nxt_rdata = {4'h0, int_mask_ff};
        default:       nxt_rdata = 8'h00;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_ff <= 8'h00;
    end else if (clk_en_in) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;

endmodule

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic       motor_supply_ok_in,
  input  wire logic [5:0] step_cmd_in,
  output logic [5:0]      pins_out
);
  logic seen_ff;
  // remember the first time the motor supply came good
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seen_ff <= 1'b0;
    end else if (motor_supply_ok_in) begin
      seen_ff <= 1'b1;
    end
  end
  // idle until supply
  // pins stay low before that, so no drive into an unpowered bridge
  assign pins_out = (seen_ff === 1'b1) ? step_cmd_in : 6'h00;
endmodule

// >>> stepper_ctrl_chk.sv
`timescale 1ns/1ps
module stepper_ctrl_chk
  import stepper_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        clk_en_in,
  input wire logic        standby_n_in,
  input wire logic        direction_first_in,
  input wire logic        level_in_first_coil_hi_in,
  input wire logic        level_in_first_coil_lo_in,
  input wire logic        thermal_trip_in,
  input wire logic [1:0]  overcurrent_trip_in,
  input wire logic        motor_supply_ok_in,
  input wire logic        logic_supply_ok_in,
  input wire logic [1:0]  pos_out,
  input wire logic [1:0]  pos_oe_out,
  input wire logic [1:0]  neg_out,
  input wire logic [1:0]  neg_oe_out,
  input wire logic [3:0]  setpoint_code_out,
  input wire logic [13:0] setpoint_pct_out,
  input wire logic        chopper_osc_pin_out
);
  logic all_off;
  // every bridge output released
  assign all_off = (pos_oe_out == 2'h0) && (neg_oe_out == 2'h0);
  // frozen state would break every one-cycle relation
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in || !clk_en_in);
  function automatic logic [6:0] pct_f(input logic [1:0] c);
    return c == SP_FULL ? PCT_FULL : c == SP_71 ? PCT_71 : c == SP_38 ? PCT_38 : PCT_ZERO;
  endfunction
  a_code_follows: assert property (1'b1 |=> setpoint_code_out[1:0] ==
    $past({level_in_first_coil_hi_in, level_in_first_coil_lo_in}))
    else $error("set-point code lags level inputs");
  a_pct_mapped: assert property (setpoint_pct_out[13:7] == pct_f(setpoint_code_out[3:2]))
    else $error("percent does not match code");
  a_dir_drive: assert property (pos_oe_out[0] |->
    pos_out[0] == $past(direction_first_in) && neg_out[0] != pos_out[0])
    else $error("bridge polarity wrong");
  a_zero_hiz: assert property (
    !level_in_first_coil_hi_in && !level_in_first_coil_lo_in |=> !pos_oe_out[0] && !neg_oe_out[0])
    else $error("zero level still driven");
  a_standby_off: assert property (!standby_n_in |=> all_off && !chopper_osc_pin_out)
    else $error("standby left drive or oscillator on");
  a_thermal_off: assert property ($rose(thermal_trip_in) |-> ##3 all_off)
    else $error("thermal trip did not cut outputs");
  a_thermal_held: assert property (
    $rose(thermal_trip_in) && standby_n_in ##1 standby_n_in [*8] |-> all_off)
    else $error("thermal latch released early");
  a_supply_off: assert property (!motor_supply_ok_in || !logic_supply_ok_in |=> all_off)
    else $error("outputs on with supply low");
  a_oc_phase: assert property ($rose(overcurrent_trip_in[1]) |-> ##3
    !pos_oe_out[1] && !neg_oe_out[1])
    else $error("overcurrent phase still driven");
  a_oc_held: assert property (
    $rose(overcurrent_trip_in[1]) && standby_n_in ##1 standby_n_in [*6] |-> !pos_oe_out[1])
    else $error("overcurrent latch released early");
  c_thermal: cover property ($rose(thermal_trip_in));
  c_oc: cover property ($rose(overcurrent_trip_in[1]));
  c_wake: cover property (!standby_n_in ##1 standby_n_in);
endmodule
bind stepper_ctrl stepper_ctrl_chk stepper_ctrl_chk_i (.*);

// >>> bipolar_stepper_bridge_control_test.sv
`timescale 1ns/1ps
module bipolar_stepper_bridge_control_test;
  import stepper_pkg::*;
  logic mclk_in = 1'b0, nrst_in = 1'b0, standby_n_in = 1'b1, clk_en_in = 1'b1;
  logic thermal_trip_in = 1'b0, motor_supply_ok_in = 1'b0, logic_supply_ok_in = 1'b1;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, chopper_osc_pin_out, irq_out;
  logic [1:0] overcurrent_trip_in = 2'h0, sense_reached_in = 2'h0;
  logic [1:0] pos_out, pos_oe_out, neg_out, neg_oe_out;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic [5:0] cmd = 6'h00, pins;
  logic [3:0] setpoint_code_out, lv;
  logic [13:0] setpoint_pct_out;
  logic [1:0] en, dr;
  logic direction_first_in, level_in_first_coil_hi_in, level_in_first_coil_lo_in;
  logic direction_second_in, level_in_second_coil_hi_in, level_in_second_coil_lo_in;
  int err_total = 0, samples_checked = 0;
  // host pins packed {dir, hi, lo} per phase, second phase on top
  assign {direction_second_in, level_in_second_coil_hi_in, level_in_second_coil_lo_in,
          direction_first_in, level_in_first_coil_hi_in, level_in_first_coil_lo_in} = pins;
  host_model host_model_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .motor_supply_ok_in(motor_supply_ok_in), .step_cmd_in(cmd), .pins_out(pins));
  stepper_ctrl stepper_ctrl_i (.*);
  always #50 mclk_in = ~mclk_in;
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // land on a falling edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic oe_is(input logic [1:0] w);
    chk("oe", {w, w}, {pos_oe_out, neg_oe_out});
    @(posedge mclk_in);
  endtask
  // bounded wait; a hang ends the run with a mismatch
  task automatic wait_oe(input logic [1:0] w);
    for (int i = 0; i < 60 && pos_oe_out !== w; i++) @(negedge mclk_in);
    chk("oe_wait", w, pos_oe_out);
    if (pos_oe_out !== w) begin
      complete_run();
    end else begin
      @(posedge mclk_in);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk(n, e, reg_rdata_out & m);
  endtask
  function automatic logic [6:0] pct_exp(input logic [1:0] c);
    case (c)
      2'h3: return 7'h64;
      2'h2: return 7'h47;
      2'h1: return 7'h26;
      default: return 7'h00;
    endcase
  endfunction
  initial begin
    void'($urandom(87));
    repeat (12) @(posedge mclk_in);
    nrst_in <= 1'b1;
    motor_supply_ok_in <= 1'b1;
    // reset values, a refused write, an unmapped place
    rchk("ctrl", ADDR_CTRL, 8'hFF, 8'h01);
    rchk("period", ADDR_PERIOD, 8'hFF, 8'h64);
    rchk("mask", ADDR_INT_MASK, 8'hFF, 8'h00);
    rchk("unmapped", 3'h6, 8'hFF, 8'h00);
    wr(ADDR_FAULT, 8'hFF);
    rchk("fault", ADDR_FAULT, 8'h1F, 8'h10);
    wr(ADDR_PERIOD, 8'h08);
    rchk("period", ADDR_PERIOD, 8'hFF, 8'h08);
    // every level code forced first, then random steps
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk_in);
      cmd <= k == 0 ? 6'h00 : k == 1 ? 6'h3F : k == 2 ? 6'h0A : k == 3 ? 6'h15 : 6'($urandom);
      tick(3);
      lv = {cmd[4:3], cmd[1:0]};
      en = {|cmd[4:3], |cmd[1:0]};
      dr = {cmd[5], cmd[2]};
      chk("code", lv, setpoint_code_out);
      chk("pct", {pct_exp(lv[3:2]), pct_exp(lv[1:0])}, setpoint_pct_out);
      chk("pos", dr & en, pos_out & en);
      chk("neg", ~dr & en, neg_out & en);
      oe_is(en);
    end
    cmd <= 6'h3F;
    tick(3);
    @(posedge mclk_in);
    sense_reached_in <= 2'h1;
    wait_oe(2'h2);
    sense_reached_in <= 2'h0;
    wait_oe(2'h3);
    thermal_trip_in <= 1'b1;
    tick(4);
    oe_is(2'h0);
    thermal_trip_in <= 1'b0;
    tick(10);
    oe_is(2'h0);
    rchk("fault", ADDR_FAULT, 8'h07, 8'h01);
    rchk("stat", ADDR_INT_STAT, 8'h0F, 8'h01);
    chk("irq", 1'b0, irq_out);
    wr(ADDR_INT_MASK, 8'h0F);
    @(negedge mclk_in);
    chk("irq", 1'b1, irq_out);
    @(posedge mclk_in);
    standby_n_in <= 1'b0;
    tick(2);
    chk("osc", 1'b0, chopper_osc_pin_out);
    oe_is(2'h0);
    standby_n_in <= 1'b1;
    wait_oe(2'h3);
    rchk("fault", ADDR_FAULT, 8'h07, 8'h00);
    wr(ADDR_INT_STAT, 8'h01);
    rchk("stat", ADDR_INT_STAT, 8'h0F, 8'h00);
    chk("irq", 1'b0, irq_out);
    @(posedge mclk_in);
    overcurrent_trip_in <= 2'h2;
    tick(4);
    oe_is(2'h1);
    overcurrent_trip_in <= 2'h0;
    tick(10);
    oe_is(2'h1);
    rchk("fault", ADDR_FAULT, 8'h07, 8'h04);
    @(posedge mclk_in);
    standby_n_in <= 1'b0;
    @(posedge mclk_in);
    standby_n_in <= 1'b1;
    wait_oe(2'h3);
    logic_supply_ok_in <= 1'b0;
    tick(2);
    oe_is(2'h0);
    logic_supply_ok_in <= 1'b1;
    wait_oe(2'h3);
    rchk("stat", ADDR_INT_STAT, 8'h0F, 8'h0C);
    // chopper disabled by software: bridges off, pin quiet, then running again
    wr(ADDR_CTRL, 8'h00);
    tick(2);
    chk("osc", 1'b0, chopper_osc_pin_out);
    oe_is(2'h0);
    wr(ADDR_CTRL, 8'h01);
    wait_oe(2'h3);
    for (int i = 0; i < 20 && chopper_osc_pin_out !== 1'b1; i++) @(negedge mclk_in);
    chk("osc_run", 1'b1, chopper_osc_pin_out);
    // frozen clock enable holds outputs; levels restored before release
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    cmd <= 6'h00;
    tick(3);
    chk("frozen", 4'hF, setpoint_code_out);
    oe_is(2'h3);
    cmd <= 6'h3F;
    @(posedge mclk_in);
    clk_en_in <= 1'b1;
    tick(2);
    oe_is(2'h3);
    complete_run();
  end
endmodule
